// [src/pacc_top.sv]
// Period and pulse accumulator channel with AXI4-Lite register slave
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module pacc_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [4:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	// Write data channel
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// Write response channel
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// Read address channel
	input wire logic [4:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	// Read data channel
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Measured pin and timebase ticks
	input wire logic signal_in,
	input wire logic tb_one_tick,
	input wire logic tb_two_tick,
	// Completion flags
	output logic chan_flag,
	output logic dma_request
);
	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte-lane merge of a write
	function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Legal channel index
	function automatic logic chan_ok(input logic [7:0] c);
		return (c <= pacc_pkg::CHAN_A_MAX) ||
			(pacc_pkg::DUAL_ENGINE && c >= pacc_pkg::CHAN_B_MIN && c <= pacc_pkg::CHAN_B_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	pacc_pkg::pacc_cfg_t cfg_reg, cfg_next; // Channel configuration
	logic [22:0] max_reg, max_next; // Periods per result
	logic [22:0] sample_reg, sample_next; // Interim interval
	logic aw_full_reg, aw_full_next; // Write address held
	logic [4:0] awaddr_reg, awaddr_next;
	logic w_full_reg, w_full_next; // Write data held
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic done_clr, dma_clr; // W1C pulses
	logic [31:0] wv, rd; // Merged write, read word
	logic cfg_open; // Configuration writable

	pacc_pkg::pacc_state_t state_reg, state_next; // Sequencer
	logic sig_meta_reg, sig_sync_reg, sig_prev_reg; // Pin synchroniser
	logic in_pulse_reg, in_pulse_next; // Measuring phase active
	logic [23:0] accum_reg, accum_next; // In-progress total
	logic [23:0] pending_reg, pending_next; // Ticks since last update
	logic [22:0] samp_cnt_reg, samp_cnt_next; // Interim interval counter
	logic [23:0] count_reg, count_next; // Periods so far
	logic [7:0] stat_acc_reg, stat_acc_next; // in_progress_overflow_status
	logic [23:0] result_reg, result_next; // Completed total
	logic [7:0] status_reg, status_next; // Completed status
	logic valid_reg, valid_next; // A result exists
	logic flag_reg, flag_next; // Channel completion flag
	logic dma_reg, dma_next; // DMA request flag

	logic rise, fall, tick, pulse_mode, start_edge, end_edge, interim, last;
	logic [24:0] sum;
	logic [23:0] count_inc;
	logic [22:0] samp_inc, target;

	////////////////////////////////////////////////////////////////////////////////
	// Register slave

	// Configuration other than priority frozen while the channel runs
	assign cfg_open = (cfg_reg.prio == pacc_pkg::priority_off) &&
		(state_reg == pacc_pkg::st_idle);

	// Bus next-state logic
	always_comb begin
		cfg_next = cfg_reg;
		max_next = max_reg;
		sample_next = sample_reg;
		aw_full_next = aw_full_reg;
		awaddr_next = awaddr_reg;
		w_full_next = w_full_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		done_clr = 1'b0;
		dma_clr = 1'b0;
		wv = 32'h0;
		rd = 32'h0;
		// Capture address and data in either order
		if (s_awvalid && awready_reg) begin
			aw_full_next = 1'b1;
			awaddr_next = s_awaddr;
		end
		if (s_wvalid && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next = s_wdata;
			wstrb_next = s_wstrb;
		end
		// Response taken
		if (bvalid_reg && s_bready) begin
			bvalid_next = 1'b0;
		end
		// Perform write once both halves are here
		if (aw_full_reg && w_full_reg && !bvalid_reg) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = pacc_pkg::RESP_OKAY;
			case ({awaddr_reg[4:2], 2'b00})
				pacc_pkg::OFF_CTRL: begin
					wv = merge32({16'h0, cfg_reg.channel, 3'h0, cfg_reg.mode, cfg_reg.timebase,
						cfg_reg.prio}, wdata_reg, wstrb_reg);
					// Priority always writable, so software can stop
					cfg_next.prio = pacc_pkg::pacc_prio_t'(wv[pacc_pkg::CTRL_PRIO_LSB +: 2]);
					if (cfg_open) begin
						cfg_next.timebase = pacc_pkg::pacc_tb_t'(wv[pacc_pkg::CTRL_TB_BIT]);
						cfg_next.mode = pacc_pkg::pacc_mode_t'(wv[pacc_pkg::CTRL_MODE_LSB +: 2]);
						if (chan_ok(wv[pacc_pkg::CTRL_CHAN_LSB +: 8])) begin
							cfg_next.channel = wv[pacc_pkg::CTRL_CHAN_LSB +: 8];
						end
					end
				end
				pacc_pkg::OFF_MAX: begin
					wv = merge32({9'h0, max_reg}, wdata_reg, wstrb_reg);
					if (cfg_open) begin
						max_next = wv[22:0];
					end
				end
				pacc_pkg::OFF_SAMPLE: begin
					wv = merge32({9'h0, sample_reg}, wdata_reg, wstrb_reg);
					if (cfg_open) begin
						sample_next = wv[22:0];
					end
				end
				pacc_pkg::OFF_STATUS: begin
					// Write one to clear
					done_clr = wdata_reg[pacc_pkg::STAT_DONE_BIT] & wstrb_reg[1];
					dma_clr = wdata_reg[pacc_pkg::STAT_DMA_BIT] & wstrb_reg[1];
				end
				pacc_pkg::OFF_RESULT, pacc_pkg::OFF_INTERIM, pacc_pkg::OFF_COUNT: begin
					// Read-only words ignore writes
					bresp_next = pacc_pkg::RESP_OKAY;
				end
				default: begin
					bresp_next = pacc_pkg::RESP_SLVERR;
				end
			endcase
		end
		awready_next = !aw_full_next && !bvalid_next;
		wready_next = !w_full_next && !bvalid_next;
		// Read: one outstanding
		if (rvalid_reg && s_rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
		if (s_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = pacc_pkg::RESP_OKAY;
			case ({s_araddr[4:2], 2'b00})
				pacc_pkg::OFF_CTRL: rd = {16'h0, cfg_reg.channel, 3'h0, cfg_reg.mode,
					cfg_reg.timebase, cfg_reg.prio};
				pacc_pkg::OFF_MAX: rd = {9'h0, max_reg};
				pacc_pkg::OFF_SAMPLE: rd = {9'h0, sample_reg};
				pacc_pkg::OFF_RESULT: rd = {8'h0, result_reg};
				pacc_pkg::OFF_STATUS: rd = {21'h0, valid_reg, dma_reg, flag_reg, status_reg};
				pacc_pkg::OFF_INTERIM: rd = {stat_acc_reg, accum_reg};
				pacc_pkg::OFF_COUNT: rd = {8'h0, count_reg};
				default: begin
					rd = 32'h0;
					rresp_next = pacc_pkg::RESP_SLVERR;
				end
			endcase
			rdata_next = rd;
		end
		// Next address only once the read data has gone
		arready_next = !rvalid_next;
	end

	// Bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= '{channel: pacc_pkg::CHAN_RST, mode: pacc_pkg::mode_low_time,
				timebase: pacc_pkg::timebase_one, prio: pacc_pkg::priority_off};
			max_reg <= pacc_pkg::MAX_RST;
			sample_reg <= pacc_pkg::SAMPLE_RST;
			aw_full_reg <= 1'b0;
			awaddr_reg <= 5'h00;
			w_full_reg <= 1'b0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= pacc_pkg::RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= pacc_pkg::RESP_OKAY;
		end else begin
			cfg_reg <= cfg_next;
			max_reg <= max_next;
			sample_reg <= sample_next;
			aw_full_reg <= aw_full_next;
			awaddr_reg <= awaddr_next;
			w_full_reg <= w_full_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Measurement

	// Edge and tick decode; the second sync stage is compared with its delayed copy
	assign rise = sig_sync_reg && !sig_prev_reg;
	assign fall = !sig_sync_reg && sig_prev_reg;
	assign tick = (cfg_reg.timebase == pacc_pkg::timebase_two) ? tb_two_tick : tb_one_tick;
	assign pulse_mode = !cfg_reg.mode[1];
	always_comb begin
		unique case (cfg_reg.mode)
			pacc_pkg::mode_low_time: begin
				start_edge = fall;
				end_edge = rise;
			end
			pacc_pkg::mode_high_time: begin
				start_edge = rise;
				end_edge = fall;
			end
			pacc_pkg::mode_period_falling: begin
				start_edge = fall;
				end_edge = fall;
			end
			pacc_pkg::mode_period_rising: begin
				start_edge = rise;
				end_edge = rise;
			end
		endcase
	end
	// Tick of the current clock belongs to the total as well
	assign sum = {1'b0, accum_reg} + {1'b0, pending_reg} + {24'h0, tick};
	assign count_inc = count_reg + 24'h1;
	assign samp_inc = samp_cnt_reg + 23'h1;
	assign target = (max_reg == 23'h0) ? 23'h1 : max_reg;
	assign last = count_inc >= {1'b0, target};
	assign interim = tick && (sample_reg != 23'h0) && (samp_inc == sample_reg);

	// Sequencer next-state logic
	always_comb begin
		state_next = state_reg;
		in_pulse_next = in_pulse_reg;
		accum_next = accum_reg;
		pending_next = pending_reg;
		samp_cnt_next = samp_cnt_reg;
		count_next = count_reg;
		stat_acc_next = stat_acc_reg;
		result_next = result_reg;
		status_next = status_reg;
		valid_next = valid_reg;
		flag_next = flag_reg && !done_clr;
		dma_next = dma_reg && !dma_clr;
		// Ticks keep counting through the completion steps
		if (state_reg != pacc_pkg::st_idle && in_pulse_reg && tick) begin
			pending_next = pending_reg + 24'h1;
			samp_cnt_next = samp_inc;
		end
		unique case (state_reg)
			pacc_pkg::st_idle: begin
				// Enabling starts a fresh accumulation
				if (cfg_reg.prio != pacc_pkg::priority_off) begin
					state_next = pacc_pkg::st_meas;
					in_pulse_next = 1'b0;
					accum_next = 24'h0;
					pending_next = 24'h0;
					samp_cnt_next = 23'h0;
					count_next = 24'h0;
					stat_acc_next = 8'h00;
				end
			end
			pacc_pkg::st_meas: begin
				if (in_pulse_reg && end_edge) begin
					// Pulse or period closed
					accum_next = sum[23:0];
					if (sum[24]) begin
						stat_acc_next = pacc_pkg::OVF_STATUS;
					end
					count_next = count_inc;
					pending_next = 24'h0;
					samp_cnt_next = 23'h0;
					in_pulse_next = !pulse_mode;
					if (last) begin
						state_next = pacc_pkg::st_copy_result;
					end
				end else if (!in_pulse_reg && start_edge) begin
					// Valid edge arms the interim interval
					in_pulse_next = 1'b1;
					pending_next = 24'h0;
					samp_cnt_next = 23'h0;
				end else if (in_pulse_reg && interim) begin
					// Interim update without an edge
					accum_next = sum[23:0];
					if (sum[24]) begin
						stat_acc_next = pacc_pkg::OVF_STATUS;
					end
					pending_next = 24'h0;
					samp_cnt_next = 23'h0;
				end
				// Service step done, then stop
				if (cfg_reg.prio == pacc_pkg::priority_off && state_next == pacc_pkg::st_meas) begin
					state_next = pacc_pkg::st_idle;
					in_pulse_next = 1'b0;
				end
			end
			pacc_pkg::st_copy_result: begin
				result_next = accum_reg;
				valid_next = 1'b1;
				state_next = pacc_pkg::st_copy_status;
			end
			pacc_pkg::st_copy_status: begin
				status_next = stat_acc_reg;
				stat_acc_next = 8'h00;
				state_next = pacc_pkg::st_flag;
			end
			pacc_pkg::st_flag: begin
				flag_next = 1'b1;
				dma_next = 1'b1;
				accum_next = 24'h0;
				count_next = 24'h0;
				state_next = pacc_pkg::st_meas;
			end
			default: begin
				state_next = pacc_pkg::st_idle;
			end
		endcase
	end

	// Sequencer registers and pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= pacc_pkg::st_idle;
			sig_meta_reg <= 1'b0;
			sig_sync_reg <= 1'b0;
			sig_prev_reg <= 1'b0;
			in_pulse_reg <= 1'b0;
			accum_reg <= 24'h0;
			pending_reg <= 24'h0;
			samp_cnt_reg <= 23'h0;
			count_reg <= 24'h0;
			stat_acc_reg <= 8'h00;
			result_reg <= 24'h0;
			status_reg <= 8'h00;
			valid_reg <= 1'b0;
			flag_reg <= 1'b0;
			dma_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sig_meta_reg <= signal_in;
			sig_sync_reg <= sig_meta_reg;
			sig_prev_reg <= sig_sync_reg;
			in_pulse_reg <= in_pulse_next;
			accum_reg <= accum_next;
			pending_reg <= pending_next;
			samp_cnt_reg <= samp_cnt_next;
			count_reg <= count_next;
			stat_acc_reg <= stat_acc_next;
			result_reg <= result_next;
			status_reg <= status_next;
			valid_reg <= valid_next;
			flag_reg <= flag_next;
			dma_reg <= dma_next;
		end
	end

	// Port drive
	assign s_awready = awready_reg;
	assign s_wready = wready_reg;
	assign s_bvalid = bvalid_reg;
	assign s_bresp = bresp_reg;
	assign s_arready = arready_reg;
	assign s_rvalid = rvalid_reg;
	assign s_rdata = rdata_reg;
	assign s_rresp = rresp_reg;
	assign chan_flag = flag_reg;
	assign dma_request = dma_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_finish;
		state_reg == pacc_pkg::st_copy_status ##1 state_reg == pacc_pkg::st_flag
			##1 (flag_reg && dma_reg && state_reg == pacc_pkg::st_meas);
	endsequence
	property p_order;
		state_reg == pacc_pkg::st_copy_result |=> s_finish;
	endproperty
	a_order: assert property (p_order) else $error("completion steps out of order");
	property p_result;
		state_reg == pacc_pkg::st_copy_result |=> result_reg == $past(accum_reg) && valid_reg;
	endproperty
	a_result: assert property (p_result) else $error("result not copied");
	property p_status;
		state_reg == pacc_pkg::st_copy_status |=>
			status_reg == $past(stat_acc_reg) && stat_acc_reg == 8'h00;
	endproperty
	a_status: assert property (p_status) else $error("status not moved");
	property p_ovf;
		state_reg == pacc_pkg::st_meas && in_pulse_reg && end_edge && sum[24]
			|=> stat_acc_reg == pacc_pkg::OVF_STATUS;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not marked");
	property p_single;
		state_reg == pacc_pkg::st_meas && in_pulse_reg && end_edge && max_reg <= 23'h1
			|=> state_reg == pacc_pkg::st_copy_result;
	endproperty
	a_single: assert property (p_single) else $error("one period not final");
	property p_restart;
		state_reg == pacc_pkg::st_flag |=> accum_reg == 24'h0 && count_reg == 24'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_arm;
		state_reg == pacc_pkg::st_meas && !in_pulse_reg && start_edge
			&& cfg_reg.prio != pacc_pkg::priority_off |=> in_pulse_reg && samp_cnt_reg == 23'h0;
	endproperty
	a_arm: assert property (p_arm) else $error("interim not armed");
	property p_no_interim;
		state_reg == pacc_pkg::st_meas && !end_edge && !interim |=> $stable(accum_reg);
	endproperty
	a_no_interim: assert property (p_no_interim) else $error("stray update");
	property p_stop;
		state_reg == pacc_pkg::st_meas && cfg_reg.prio == pacc_pkg::priority_off
			&& !(in_pulse_reg && end_edge && last) |=> state_reg == pacc_pkg::st_idle;
	endproperty
	a_stop: assert property (p_stop) else $error("disabled channel runs");
	property p_valid;
		valid_reg |=> valid_reg;
	endproperty
	a_valid: assert property (p_valid) else $error("result validity lost");
endmodule

// [inc/pacc_pkg.sv]
// Constants, types and field layout for the period and pulse accumulator
package pacc_pkg;
	// Register byte offsets
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_MAX = 5'h04;
	localparam logic [4:0] OFF_SAMPLE = 5'h08;
	localparam logic [4:0] OFF_RESULT = 5'h0c;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_INTERIM = 5'h14;
	localparam logic [4:0] OFF_COUNT = 5'h18;
	// Control word field positions
	localparam int CTRL_PRIO_LSB = 0;
	localparam int CTRL_TB_BIT = 2;
	localparam int CTRL_MODE_LSB = 3;
	localparam int CTRL_CHAN_LSB = 8;
	// Status word field positions
	localparam int STAT_DONE_BIT = 8;
	localparam int STAT_DMA_BIT = 9;
	localparam int STAT_VALID_BIT = 10;
	// Overflow marker for the in-progress status
	localparam logic [7:0] OVF_STATUS = 8'h80;
	// Channel index ranges
	localparam logic [7:0] CHAN_A_MAX = 8'h1f;
	localparam logic [7:0] CHAN_B_MIN = 8'h40;
	localparam logic [7:0] CHAN_B_MAX = 8'h5f;
	localparam logic DUAL_ENGINE = 1'b1;
	// Reset values
	localparam logic [7:0] CHAN_RST = 8'h00;
	localparam logic [22:0] MAX_RST = 23'h000000;
	localparam logic [22:0] SAMPLE_RST = 23'h000000;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Scheduler priority
	typedef enum logic [1:0] {
		priority_off = 2'b00,
		priority_low_level = 2'b01,
		priority_mid_level = 2'b10,
		priority_high_level = 2'b11
	} pacc_prio_t;
	// Measurement modes
	typedef enum logic [1:0] {
		mode_low_time = 2'b00,
		mode_high_time = 2'b01,
		mode_period_falling = 2'b10,
		mode_period_rising = 2'b11
	} pacc_mode_t;
	// Timebase choice
	typedef enum logic {
		timebase_one = 1'b0,
		timebase_two = 1'b1
	} pacc_tb_t;
	// Channel sequencer states
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_meas = 3'b001,
		st_copy_result = 3'b010,
		st_copy_status = 3'b011,
		st_flag = 3'b100
	} pacc_state_t;
	// Channel configuration carrier
	typedef struct packed {
		logic [7:0] channel;
		pacc_mode_t mode;
		pacc_tb_t timebase;
		pacc_prio_t prio;
	} pacc_cfg_t;
endpackage

// [verif/pacc_sig_src.sv]
// Free-running pulse source that stands in for the measured input pin
`timescale 1ns/1ps
module pacc_sig_src (
	// Clock and control
	input wire logic aclk,
	input wire logic run,
	// Pulse shape in clocks
	input wire logic [7:0] hi_len,
	input wire logic [7:0] lo_len,
	// Measured pin
	output logic signal_in
);
	////////////////////////////////////////////////////////////////
	logic [7:0] cnt; // Clocks left in the current level
	// Flip the pin each time a level has lasted its full length
	always_ff @(posedge aclk) begin
		if (!run) begin
			// Parked low so no stray edge reaches the channel
			signal_in <= 1'b0;
			cnt <= lo_len;
		end else if (cnt <= 8'h01) begin
			signal_in <= ~signal_in;
			cnt <= signal_in ? lo_len : hi_len;
		end else begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule

// [verif/tb_top.sv]
// Self-checking testbench for the period and pulse accumulator channel
`timescale 1ns/1ps
module tb_top;
	////////////////////////////////////////////////////////////////
	logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready, signal_in, tb_one_tick, tb_two_tick;
	logic chan_flag, dma_request, sig_run;
	logic [4:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, rsp;
	logic [31:0] snap_total, snap_count; // Interim snapshots
	int err_count, num_checks;
	// Device under test and input source
	pacc_top uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
		.s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .signal_in, .tb_one_tick,
		.tb_two_tick, .chan_flag, .dma_request);
	pacc_sig_src src (.aclk, .run(sig_run), .hi_len(8'h06), .lo_len(8'h0c), .signal_in);
	// 40 MHz clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		$display("wrong value at %0t: %s", $time, m);
		err_count++;
	endtask
	// Bounded waits end the run
	task automatic tmo(input int n);
		if (n > 3000) begin
			fail("wait limit used up");
			final_report;
		end
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) fail(m);
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
		num_checks++;
		if (g !== e) fail(m);
	endtask
	task automatic chk_bit(input logic g, input logic e, input string m);
		num_checks++;
		if (g !== e) fail(m);
	endtask
	////////////////////////////////////////////////////////////////
	// Bus write, both halves offered together
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw_ok, w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_awready) begin
				aw_ok = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!w_ok && s_wready) begin
				w_ok = 1'b1;
				s_wvalid <= 1'b0;
			end
			n++;
			tmo(n);
		end
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
		end while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
		chk_resp(s_bresp, er, "write response");
	endtask
	// Bus read into rd and rsp
	task automatic rdw(input logic [4:0] a);
		int n;
		n = 0;
		s_araddr <= a;
		s_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
		end while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
		end while (s_rvalid !== 1'b1);
		rd = s_rdata;
		rsp = s_rresp;
		s_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string m);
		rdw(a);
		chk_word(rd, e, m);
		chk_resp(rsp, pacc_pkg::RESP_OKAY, "read response");
	endtask
	function automatic logic [31:0] ctrl(input logic [7:0] ch, input logic [1:0] md,
		input logic tb, input logic [1:0] pr);
		return {16'h0000, ch, 3'h0, md, tb, pr};
	endfunction
	////////////////////////////////////////////////////////////////
	// One full measurement from a stopped channel
	task automatic run_meas(input logic [1:0] md, input logic tb, input logic [31:0] mx,
		input logic [31:0] ex);
		int n;
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h0a, md, tb, 2'h0), pacc_pkg::RESP_OKAY);
		repeat (8) @(posedge aclk);
		wr(pacc_pkg::OFF_MAX, mx, pacc_pkg::RESP_OKAY);
		wr(pacc_pkg::OFF_SAMPLE, 32'h007fffff, pacc_pkg::RESP_OKAY);
		wr(pacc_pkg::OFF_STATUS, 32'h00000300, pacc_pkg::RESP_OKAY);
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h0a, md, tb, 2'h1), pacc_pkg::RESP_OKAY);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			tmo(n);
		end while (chan_flag !== 1'b1);
		if (md == pacc_pkg::mode_high_time) rchk(pacc_pkg::OFF_COUNT, 32'h0, "count");
		rchk(pacc_pkg::OFF_RESULT, ex, "result");
		rchk(pacc_pkg::OFF_STATUS, 32'h00000700, "status");
		wr(pacc_pkg::OFF_STATUS, 32'h00000300, pacc_pkg::RESP_OKAY);
		chk_bit(chan_flag, 1'b0, "flag clear");
		chk_bit(dma_request, 1'b0, "dma clear");
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, sig_run} = 6'h00;
		{aresetn, tb_two_tick, tb_one_tick} = 3'h1;
		{s_awaddr, s_araddr, s_wdata, s_wstrb} = {10'h000, 32'h0, 4'hf};
		{err_count, num_checks} = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		sig_run <= 1'b1;
		@(posedge aclk);
		chk_bit(chan_flag, 1'b0, "flag after reset");
		rchk(pacc_pkg::OFF_CTRL, 32'h0, "control after reset");
		rdw(5'h1c);
		chk_word(rd, 32'h0, "unmapped data");
		chk_resp(rsp, pacc_pkg::RESP_SLVERR, "unmapped response");
		// High 6, low 12 clocks, two units each
		run_meas(pacc_pkg::mode_low_time, 1'b0, 32'h2, 32'd24);
		run_meas(pacc_pkg::mode_high_time, 1'b0, 32'h2, 32'd12);
		run_meas(pacc_pkg::mode_period_falling, 1'b0, 32'h2, 32'd36);
		run_meas(pacc_pkg::mode_period_rising, 1'b0, 32'h2, 32'd36);
		// Ticks only on the second timebase
		tb_one_tick <= 1'b0;
		tb_two_tick <= 1'b1;
		run_meas(pacc_pkg::mode_high_time, 1'b0, 32'h1, 32'd0);
		run_meas(pacc_pkg::mode_high_time, 1'b1, 32'h0, 32'd6);
		run_meas(pacc_pkg::mode_high_time, 1'b1, 32'h1, 32'd6);
		// Mode change while enabled is ignored
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h0a, 2'h0, 1'b0, 2'h3), pacc_pkg::RESP_OKAY);
		rchk(pacc_pkg::OFF_CTRL, ctrl(8'h0a, 2'h1, 1'b1, 2'h3), "locked config");
		// Disabled channel raises nothing
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h0a, 2'h1, 1'b1, 2'h0), pacc_pkg::RESP_OKAY);
		repeat (8) @(posedge aclk);
		wr(pacc_pkg::OFF_STATUS, 32'h00000300, pacc_pkg::RESP_OKAY);
		repeat (100) @(posedge aclk);
		chk_bit(chan_flag, 1'b0, "flag while off");
		// Channel index range
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h20, 2'h2, 1'b0, 2'h0), pacc_pkg::RESP_OKAY);
		rchk(pacc_pkg::OFF_CTRL, ctrl(8'h0a, 2'h2, 1'b0, 2'h0), "bad channel");
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h5f, 2'h2, 1'b0, 2'h0), pacc_pkg::RESP_OKAY);
		rchk(pacc_pkg::OFF_CTRL, ctrl(8'h5f, 2'h2, 1'b0, 2'h0), "second engine");
		// Parked low level: interim every tick, no pulse closes
		wr(pacc_pkg::OFF_MAX, 32'h00000010, pacc_pkg::RESP_OKAY);
		wr(pacc_pkg::OFF_SAMPLE, 32'h00000001, pacc_pkg::RESP_OKAY);
		wr(pacc_pkg::OFF_CTRL, ctrl(8'h0a, 2'h0, 1'b1, 2'h2), pacc_pkg::RESP_OKAY);
		repeat (40) @(posedge aclk);
		sig_run <= 1'b0;
		repeat (8) @(posedge aclk);
		rdw(pacc_pkg::OFF_INTERIM);
		snap_total = rd;
		rdw(pacc_pkg::OFF_COUNT);
		snap_count = rd;
		repeat (20) @(posedge aclk);
		rdw(pacc_pkg::OFF_INTERIM);
		chk_word({24'h0, rd[31:24]}, 32'h0, "interim status");
		chk_bit(rd[23:0] - snap_total[23:0] >= 24'd20, 1'b1, "interim total");
		rchk(pacc_pkg::OFF_COUNT, snap_count, "interim count");
		final_report;
	end
endmodule
